// ===== pkg/bsdr_pkg.sv
// Purpose: Shared constants and types of the scan data registers.
// Assumes: Opcodes are the low seven instruction bits.
// Notes: Chain layout is oe cells, input cells, output cells from the top.
package bsdr_pkg;
  localparam int CHAIN_W = 18;
  localparam int IR_W = 8;
  localparam int SEL_W = 2;
  localparam int DATA_W = 8;
  localparam int GRP_W = 4;
  localparam int OE_W = 2;
  localparam logic [IR_W-1:0] IR_RESET = 8'hFF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h2;
  localparam logic [15:0] LFSR16_TAPS = 16'hD008;
  localparam logic [7:0] LFSR8_TAPS = 8'hB8;
  localparam logic [6:0] OPC_SCAN_A = 7'h00;
  localparam logic [6:0] OPC_SAMPLE = 7'h02;
  localparam logic [6:0] OPC_SCAN_B = 7'h03;
  localparam logic [6:0] OPC_FLOAT = 7'h06;
  localparam logic [6:0] OPC_HOLD = 7'h07;
  localparam logic [6:0] OPC_RUN_TEST = 7'h09;
  localparam logic [6:0] OPC_READ_N = 7'h0A;
  localparam logic [6:0] OPC_READ_T = 7'h0B;
  localparam logic [6:0] OPC_SELF_TEST = 7'h0C;
  localparam logic [6:0] OPC_TOGGLE = 7'h0D;
  localparam logic [6:0] OPC_SEL_N = 7'h0E;
  localparam logic [6:0] OPC_SEL_T = 7'h0F;

  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011, TAP_SH_DR = 4'b0100, TAP_EX1_DR = 4'b0101,
    TAP_PA_DR = 4'b0110, TAP_EX2_DR = 4'b0111, TAP_UP_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SH_IR = 4'b1011,
    TAP_EX1_IR = 4'b1100, TAP_PA_IR = 4'b1101, TAP_EX2_IR = 4'b1110,
    TAP_UP_IR = 4'b1111
  } bsdr_tap_t;
  typedef enum logic [1:0] {
    DR_BYPASS = 2'b00, DR_CHAIN = 2'b01, DR_SELECT = 2'b10
  } bsdr_dr_t;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00, MODE_TEST = 2'b01, MODE_MODTEST = 2'b10
  } bsdr_mode_t;
  typedef enum logic [1:0] {
    OP_TOGGLE = 2'b00, OP_PATTERN = 2'b01, OP_SIGNATURE = 2'b10,
    OP_BOTH = 2'b11
  } bsdr_op_t;
  typedef enum logic [1:0] {
    CAP_HOLD = 2'b00, CAP_PINS = 2'b01, CAP_INVERT = 2'b10
  } bsdr_cap_t;
  typedef struct packed {
    bsdr_dr_t dr;
    bsdr_mode_t mode;
    bsdr_cap_t cap;
    logic run;
    logic tog;
  } bsdr_dec_t;
endpackage

// ===== pkg/bsdr_tap_if.sv
// Purpose: Carries the test access port state to the data registers.
// Assumes: state changes on the rising test clock edge and at reset; next also follows tms.
// Notes: next is the state that the coming edge enters.
`timescale 1ns/10ps
interface bsdr_tap_if;
  import bsdr_pkg::*;
  bsdr_tap_t state;
  bsdr_tap_t next;
  modport ctl (output state, output next);
  modport mon (input state, input next);
endinterface

// ===== design/bsdr_sync.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module bsdr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsdr_sync_st_t;
  bsdr_sync_st_t r_q;
  bsdr_sync_st_t r_d;

  always_comb begin
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;
endmodule

// ===== design/bsdr_tap.sv
// Purpose: Test access port state machine on the test clock.
// Assumes: The mode select pin is synchronous to the test clock.
// Notes: Five clocks with mode select high always reach reset.
`timescale 1ns/10ps
module bsdr_tap (
  input wire logic tck,
  input wire logic resetn,
  input wire logic tms,
  bsdr_tap_if.ctl tap
);
  import bsdr_pkg::*;

  typedef struct packed {
    bsdr_tap_t st;
  } bsdr_tap_st_t;
  bsdr_tap_st_t s_q;
  bsdr_tap_st_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      TAP_RESET: s_d.st = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: s_d.st = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: s_d.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: s_d.st = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: s_d.st = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: s_d.st = tms ? TAP_UP_DR : TAP_PA_DR;
      TAP_PA_DR: s_d.st = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: s_d.st = tms ? TAP_UP_DR : TAP_SH_DR;
      TAP_UP_DR: s_d.st = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: s_d.st = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: s_d.st = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: s_d.st = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: s_d.st = tms ? TAP_UP_IR : TAP_PA_IR;
      TAP_PA_IR: s_d.st = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: s_d.st = tms ? TAP_UP_IR : TAP_SH_IR;
      TAP_UP_IR: s_d.st = tms ? TAP_SEL_DR : TAP_IDLE;
      default: s_d.st = TAP_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      s_q.st <= TAP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign tap.state = s_q.st;
  assign tap.next = s_d.st;
endmodule

// ===== design/bsdr_top.sv
// Purpose: Scan data registers and opcode decode of an octal buffer.
// Assumes: clk runs at 250 MHz; tck is slower than clk / 3.
// Notes: Scan logic runs on tck; the pin buffers run on clk.
`timescale 1ns/10ps
module bsdr_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [bsdr_pkg::OE_W-1:0] oe_n_in,
  input wire logic [bsdr_pkg::DATA_W-1:0] data_in,
  output logic [bsdr_pkg::DATA_W-1:0] data_out,
  output logic [bsdr_pkg::DATA_W-1:0] data_out_oe_n
);
  import bsdr_pkg::*;

  // ---------------------------------------------------------------
  // Types and decode
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [CHAIN_W-1:0] chain_sh;
    logic [CHAIN_W-1:0] chain;
    logic [SEL_W-1:0] sel_sh;
    logic [SEL_W-1:0] sel;
    logic byp;
    bsdr_mode_t mode;
    logic flag;
    logic tdo;
    logic tdo_oe_n;
  } bsdr_tst_t;

  typedef struct packed {
    logic flag;
    bsdr_mode_t mode;
    logic [CHAIN_W-1:0] cells;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] dout_oe_n;
  } bsdr_cst_t;

  function automatic bsdr_dec_t decode(input logic [IR_W-1:0] ir);
    bsdr_dec_t r;
    r = '{DR_BYPASS, MODE_NORMAL, CAP_HOLD, 1'b0, 1'b0};
    case (ir[6:0])
      OPC_SCAN_A, OPC_SCAN_B: begin
        r.dr = DR_CHAIN;
        r.mode = MODE_TEST;
        r.cap = CAP_PINS;
      end
      OPC_SAMPLE: begin
        r.dr = DR_CHAIN;
        r.cap = CAP_PINS;
      end
      OPC_READ_N: r.dr = DR_CHAIN;
      OPC_READ_T: begin
        r.dr = DR_CHAIN;
        r.mode = MODE_TEST;
      end
      OPC_SELF_TEST: begin
        r.dr = DR_CHAIN;
        r.cap = CAP_INVERT;
      end
      OPC_SEL_N: r.dr = DR_SELECT;
      OPC_SEL_T: begin
        r.dr = DR_SELECT;
        r.mode = MODE_TEST;
      end
      OPC_RUN_TEST: begin
        r.mode = MODE_TEST;
        r.run = 1'b1;
      end
      OPC_TOGGLE: begin
        r.mode = MODE_TEST;
        r.tog = 1'b1;
      end
      OPC_FLOAT: r.mode = MODE_MODTEST;
      OPC_HOLD: r.mode = MODE_TEST;
      default: r.dr = DR_BYPASS;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] step16(input logic [15:0] s);
    return {s[14:0], ^(s & LFSR16_TAPS)};
  endfunction

  function automatic logic [7:0] step8(input logic [7:0] s);
    return {s[6:0], ^(s & LFSR8_TAPS)};
  endfunction

  // ---------------------------------------------------------------
  // Test clock domain
  // ---------------------------------------------------------------
  bsdr_tap_if tap_if ();
  bsdr_tst_t t_q;
  bsdr_tst_t t_d;
  bsdr_cst_t c_q;
  bsdr_cst_t c_d;
  bsdr_dec_t dec;
  logic [CHAIN_W-1:0] pins_t;
  logic [OE_W+DATA_W-1:0] pins_s;
  logic [DATA_W-1:0] core_t;
  logic [OE_W+DATA_W-1:0] pins_c;
  logic flag_c;

  bsdr_tap u_tap (
    .tck(tck),
    .resetn(resetn),
    .tms(tms),
    .tap(tap_if)
  );

  bsdr_sync #(.W(OE_W + DATA_W)) u_tck_sync (
    .clk(tck),
    .resetn(resetn),
    .d({oe_n_in, data_in}),
    .q(pins_s)
  );

  // Core outputs are rebuilt here so that no word crosses from clk.
  assign core_t = (t_q.mode == MODE_TEST) ? t_q.chain[15:8] :
    pins_s[DATA_W-1:0];
  // Pins and core outputs line up with the chain layout.
  assign pins_t = {pins_s, core_t};

  assign dec = decode(t_q.ir);

  always_comb begin
    t_d = t_q;
    case (tap_if.state)
      TAP_RESET: begin
        t_d.ir = IR_RESET;
        t_d.sel = SEL_RESET;
        t_d.sel_sh = SEL_RESET;
      end
      TAP_IDLE: begin
        // The two enable cells stay out of every algorithm.
        if (dec.run) begin
          case (bsdr_op_t'(t_q.sel))
            OP_TOGGLE: begin
              t_d.chain_sh[15:8] = pins_t[15:8];
              t_d.chain_sh[7:0] = ~t_q.chain_sh[7:0];
            end
            OP_PATTERN: t_d.chain_sh[15:0] = step16(t_q.chain_sh[15:0]);
            OP_SIGNATURE: begin
              t_d.chain_sh[15:0] = step16(t_q.chain_sh[15:0]);
              t_d.chain_sh[15:8] = t_d.chain_sh[15:8] ^ pins_t[15:8];
            end
            OP_BOTH: begin
              t_d.chain_sh[15:8] = step8(t_q.chain_sh[15:8]) ^
                pins_t[15:8];
              t_d.chain_sh[7:0] = step8(t_q.chain_sh[7:0]);
            end
            default: t_d.chain_sh = t_q.chain_sh;
          endcase
          // Signature analysis holds the output shadow cells.
          t_d.chain[15:8] = t_d.chain_sh[15:8];
          if (bsdr_op_t'(t_q.sel) != OP_SIGNATURE) begin
            t_d.chain[7:0] = t_d.chain_sh[7:0];
          end
        end else if (dec.tog) begin
          t_d.chain_sh[7:0] = ~t_q.chain_sh[7:0];
          t_d.chain[7:0] = t_d.chain_sh[7:0];
        end
      end
      TAP_CAP_DR: begin
        case (dec.dr)
          DR_CHAIN: begin
            if (dec.cap == CAP_PINS) begin
              t_d.chain_sh = pins_t;
            end else if (dec.cap == CAP_INVERT) begin
              t_d.chain_sh = ~t_q.chain;
            end
          end
          DR_SELECT: t_d.sel_sh = t_q.sel_sh;
          default: t_d.byp = 1'b0;
        endcase
      end
      TAP_SH_DR: begin
        case (dec.dr)
          DR_CHAIN: t_d.chain_sh = {tdi, t_q.chain_sh[CHAIN_W-1:1]};
          DR_SELECT: t_d.sel_sh = {tdi, t_q.sel_sh[SEL_W-1]};
          default: t_d.byp = tdi;
        endcase
      end
      TAP_UP_DR: begin
        if (dec.dr == DR_CHAIN) begin
          t_d.chain = t_q.chain_sh;
        end else if (dec.dr == DR_SELECT) begin
          t_d.sel = t_q.sel_sh;
        end
      end
      TAP_CAP_IR: t_d.ir_sh = IR_CAPTURE;
      TAP_SH_IR: t_d.ir_sh = {tdi, t_q.ir_sh[IR_W-1:1]};
      TAP_UP_IR: t_d.ir = t_q.ir_sh;
      default: t_d.byp = t_q.byp;
    endcase
    // The serial output shows the low bit of the path being entered.
    t_d.tdo_oe_n = 1'b1;
    if (tap_if.next == TAP_SH_IR) begin
      t_d.tdo = t_d.ir_sh[0];
      t_d.tdo_oe_n = 1'b0;
    end else if (tap_if.next == TAP_SH_DR) begin
      t_d.tdo_oe_n = 1'b0;
      case (dec.dr)
        DR_CHAIN: t_d.tdo = t_d.chain_sh[0];
        DR_SELECT: t_d.tdo = t_d.sel_sh[0];
        default: t_d.tdo = t_d.byp;
      endcase
    end
    t_d.mode = decode(t_d.ir).mode;
    // A toggle tells the pin side that mode or shadow cells changed.
    t_d.flag = t_q.flag ^ ({t_d.mode, t_d.chain} != {t_q.mode, t_q.chain});
  end

  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      t_q <= '0;
      t_q.ir <= IR_RESET;
      t_q.sel_sh <= SEL_RESET;
      t_q.sel <= SEL_RESET;
      t_q.tdo_oe_n <= 1'b1;
    end else begin
      t_q <= t_d;
    end
  end

  assign tdo = t_q.tdo;
  assign tdo_oe_n = t_q.tdo_oe_n;

  // ---------------------------------------------------------------
  // System clock domain: pin buffers
  // ---------------------------------------------------------------
  bsdr_sync #(.W(OE_W + DATA_W)) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .d({oe_n_in, data_in}),
    .q(pins_c)
  );

  bsdr_sync #(.W(1)) u_flag_sync (
    .clk(clk),
    .resetn(resetn),
    .d(t_q.flag),
    .q(flag_c)
  );

  always_comb begin
    logic [OE_W-1:0] en_n;
    logic [DATA_W-1:0] core_in;
    en_n = pins_c[OE_W+DATA_W-1:DATA_W];
    core_in = pins_c[DATA_W-1:0];
    c_d = c_q;
    // The word is stable for a whole test clock while the flag settles.
    if (flag_c != c_q.flag) begin
      c_d.flag = flag_c;
      c_d.mode = t_q.mode;
      c_d.cells = t_q.chain;
    end
    if (c_q.mode == MODE_TEST) begin
      core_in = c_q.cells[15:8];
      en_n = c_q.cells[17:16];
    end else if (c_q.mode == MODE_MODTEST) begin
      en_n = '1;
    end
    c_d.dout = (c_q.mode == MODE_TEST) ? c_q.cells[7:0] : core_in;
    c_d.dout_oe_n = {{GRP_W{en_n[1]}}, {GRP_W{en_n[0]}}};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      c_q <= '0;
      c_q.dout_oe_n <= '1;
    end else begin
      c_q <= c_d;
    end
  end

  assign data_out = c_q.dout;
  assign data_out_oe_n = c_q.dout_oe_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ir_capture_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_CAP_IR |=>
    t_q.ir_sh == IR_CAPTURE)
    else $error("Instruction capture value wrong.");
  ir_reset_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_RESET |=>
    t_q.ir == IR_RESET && dec.dr == DR_BYPASS)
    else $error("Instruction not reset to bypass.");
  sel_reset_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_RESET |=>
    t_q.sel == SEL_RESET)
    else $error("Selector not reset.");
  sel_hold_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_CAP_DR &&
    dec.dr == DR_SELECT |=> $stable(t_q.sel_sh))
    else $error("Selector changed at capture.");
  byp_zero_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_CAP_DR && dec.dr == DR_BYPASS
    ##1 tap_if.state == TAP_SH_DR |-> !t_q.byp && t_q.tdo == 1'b0)
    else $error("Shortcut did not capture zero.");
  chain_frozen_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_RESET |=>
    $stable(t_q.chain) && $stable(t_q.chain_sh))
    else $error("Chain changed in reset state.");
  chain_shift_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_SH_DR && dec.dr == DR_CHAIN |=>
    t_q.chain_sh == {$past(tdi), $past(t_q.chain_sh[CHAIN_W-1:1])})
    else $error("Chain shift order wrong.");
  chain_capture_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_CAP_DR &&
    dec.cap == CAP_PINS && dec.dr == DR_CHAIN |=>
    t_q.chain_sh == $past(pins_t))
    else $error("Chain capture source wrong.");
  opcode_msb_a: assert property (@(posedge tck)
    disable iff (!resetn) decode({~t_q.ir[7], t_q.ir[6:0]}) == dec)
    else $error("Opcode bit 7 changed decode.");
  shadow_update_a: assert property (@(posedge tck)
    disable iff (!resetn) tap_if.state == TAP_UP_DR && dec.dr == DR_CHAIN |=>
    t_q.chain == $past(t_q.chain_sh))
    else $error("Shadow cells not updated.");
  test_out_a: assert property (@(posedge clk)
    disable iff (!resetn) c_q.mode == MODE_TEST |=>
    data_out == $past(c_q.cells[7:0]))
    else $error("Test mode output not from cells.");
  float_out_a: assert property (@(posedge clk)
    disable iff (!resetn) c_q.mode == MODE_MODTEST |=> data_out_oe_n == '1)
    else $error("Outputs not floating.");
  normal_oe_a: assert property (@(posedge clk)
    disable iff (!resetn) c_q.mode == MODE_NORMAL |=>
    data_out_oe_n[DATA_W-1] == $past(pins_c[OE_W+DATA_W-1]))
    else $error("Group enable not followed.");
  run_cov: cover property (@(posedge tck) disable iff (!resetn)
    tap_if.state == TAP_IDLE && dec.run);
  scan_cov: cover property (@(posedge tck) disable iff (!resetn)
    tap_if.state == TAP_UP_DR && dec.dr == DR_CHAIN);
  sel_cov: cover property (@(posedge tck) disable iff (!resetn)
    tap_if.state == TAP_UP_DR && dec.dr == DR_SELECT);
endmodule

// ===== tb/bsdr_jtag_model.sv
// Purpose: Behavioural scan controller driving the four-wire test port.
// Assumes: The test clock runs only inside step calls, period 48 ns.
// Notes: Serial data goes out and comes back least significant bit first.
`timescale 1ns/10ps
module bsdr_jtag_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------
  // One test clock period; the reply is taken while the clock is low.
  // A released output reads as unknown so that a floating bit never matches.
  task automatic step(input logic m, input logic d, output logic q);
    q = tdo_oe_n ? 1'bx : tdo;
    tms = m;
    tdi = d;
    #24 tck = 1'b1;
    #24 tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic b;
    for (int i = 0; i < 5; i++) begin
      step(1'b1, tdi, b);
    end
    step(1'b0, tdi, b);
  endtask

  // Runs one scan from idle back to idle; the offset breaks phase lock.
  task automatic frame(input logic ir, input int n, input logic [19:0] d,
                       output logic [19:0] q);
    logic b;
    q = '0;
    #1.3;
    step(1'b1, tdi, b);
    if (ir) begin
      step(1'b1, tdi, b);
    end
    step(1'b0, tdi, b);
    step(1'b0, tdi, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], q[i]);
    end
    step(1'b1, tdi, b);
    step(1'b0, tdi, b);
    tdi = ~tdi;
  endtask

  task automatic scan_ir(input logic [7:0] d, output logic [7:0] q);
    logic [19:0] r;
    frame(1'b1, 8, {12'h000, d}, r);
    q = r[7:0];
  endtask

  task automatic scan_dr(input logic [19:0] d, output logic [19:0] q);
    frame(1'b0, 20, d, q);
  endtask
endmodule

// ===== tb/boundary_scan_data_regs_decode_tb.sv
// Purpose: Self-checking bench for the scan data registers and decode.
// Assumes: Every data scan shifts 20 bits through the selected path.
// Notes: Register contents after a scan are the top bits shifted in.
`timescale 1ns/10ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module boundary_scan_data_regs_decode_tb;
  import bsdr_pkg::*;
  logic clk;
  logic resetn;
  logic tck, tms, tdi, tdo, tdo_oe_n, b;
  logic [OE_W-1:0] oe_n_in;
  logic [DATA_W-1:0] data_in, data_out, data_out_oe_n, prev;
  logic [7:0] ir_q;
  logic [19:0] din, dq, dexp, keep;
  logic [6:0] opc;
  int len;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  bsdr_top i_dut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .oe_n_in(oe_n_in),
    .data_in(data_in), .data_out(data_out),
    .data_out_oe_n(data_out_oe_n));
  bsdr_jtag_model i_jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic int exp_len(input logic [6:0] c);
    case (c)
      OPC_SCAN_A, OPC_SAMPLE, OPC_SCAN_B, OPC_READ_N, OPC_READ_T,
      OPC_SELF_TEST: exp_len = CHAIN_W;
      OPC_SEL_N, OPC_SEL_T: exp_len = SEL_W;
      default: exp_len = 1;
    endcase
  endfunction

  function automatic bsdr_mode_t exp_mode(input logic [6:0] c);
    case (c)
      OPC_FLOAT: exp_mode = MODE_MODTEST;
      OPC_SCAN_A, OPC_SCAN_B, OPC_HOLD, OPC_RUN_TEST, OPC_READ_T,
      OPC_TOGGLE, OPC_SEL_T: exp_mode = MODE_TEST;
      default: exp_mode = MODE_NORMAL;
    endcase
  endfunction

  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic load(input logic [6:0] c);
    i_jtag.scan_ir({1'($urandom), c}, ir_q);
    `CHK(ir_q, IR_CAPTURE)
    repeat (6) @(negedge clk);
  endtask

  task automatic pins(input logic [1:0] oe, input logic [7:0] d);
    @(negedge clk);
    oe_n_in = oe;
    data_in = d;
    repeat (5) @(negedge clk);
  endtask

  task automatic chk_out(input logic [7:0] d, input logic [7:0] oe);
    `CHK(data_out_oe_n, oe)
    `CHK(data_out | oe, d | oe)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    oe_n_in = '0;
    data_in = '0;
    void'($urandom(32'h4D6D));
    repeat (2) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    repeat (2) @(negedge clk);
    i_jtag.reset_tap();
    din = 20'($urandom);
    i_jtag.scan_dr(din, dq);
    `CHK(dq[0], 1'b0)
    `CHK(dq[19:1], din[18:0])
    `CHK(tdo_oe_n, 1'b1)
    load(OPC_SEL_N);
    i_jtag.scan_dr(20'h40000, dq);
    `CHK(dq[1:0], SEL_RESET)
    i_jtag.scan_dr(20'hC0000, dq);
    `CHK(dq[1:0], 2'h1)
    i_jtag.reset_tap();
    load(OPC_SEL_N);
    i_jtag.scan_dr(20'h00000, dq);
    `CHK(dq[1:0], SEL_RESET)
    // The selector now holds the toggle operation.
    pins(2'($urandom), 8'($urandom));
    load(OPC_SAMPLE);
    din = 20'($urandom);
    i_jtag.scan_dr(din, dq);
    `CHK(dq[17:0], {oe_n_in, data_in, data_in})
    load(OPC_SCAN_B);
    chk_out(din[9:2], {{GRP_W{din[19]}}, {GRP_W{din[18]}}});
    for (int k = 0; k < 2; k++) begin
      load(k == 0 ? OPC_RUN_TEST : OPC_TOGGLE);
      prev = data_out;
      i_jtag.step(1'b0, 1'b0, b);
      repeat (6) @(negedge clk);
      `CHK(data_out, ~prev)
    end
    load(OPC_SELF_TEST);
    keep = 20'($urandom);
    i_jtag.scan_dr(keep, dq);
    i_jtag.scan_dr(20'h00000, dq);
    `CHK(dq[17:0], ~keep[19:2])
    load(OPC_READ_N);
    i_jtag.scan_dr(keep, dq);
    `CHK(dq[17:0], 18'h00000)
    i_jtag.reset_tap();
    load(OPC_READ_N);
    i_jtag.scan_dr(20'h00000, dq);
    `CHK(dq[17:0], keep[19:2])
    for (int k = 0; k < 40; k++) begin
      opc = (k < 32) ? 7'(k) : 7'($urandom_range(127, 32));
      pins(2'($urandom), 8'($urandom));
      load(opc);
      case (exp_mode(opc))
        MODE_MODTEST: `CHK(data_out_oe_n, 8'hFF)
        MODE_NORMAL: chk_out(data_in,
          {{GRP_W{oe_n_in[1]}}, {GRP_W{oe_n_in[0]}}});
        default: ;
      endcase
      len = exp_len(opc);
      din = 20'($urandom);
      i_jtag.scan_dr(din, dq);
      dexp = din << len;
      dexp = dexp >> len;
      dq = dq >> len;
      `CHK(dq, dexp)
    end
    final_report();
  end
endmodule
